// [design/apr_pkg.sv]
/*
  constants for the front-end power, reset and converter control registers.
  assumes a 32-bit ahb-lite slave port with each register on one aligned word.
*/
`default_nettype none

package apr_pkg;

  // ****************************************
  // register indices, byte address = 4 * index
  // ****************************************
  localparam logic [6:0] IDX_RESET_CONTROL = 7'h00;
  localparam logic [6:0] IDX_SERIAL_RESET_ENABLE = 7'h02;
  localparam logic [6:0] IDX_POWER_MODE_CONTROL = 7'h08;
  localparam logic [6:0] IDX_CONVERSION_RESTART = 7'h0B;
  localparam logic [6:0] IDX_CONVERTER_AUX_CONTROL = 7'h12;
  localparam logic [6:0] IDX_RESULT_AVAILABLE_FLAG = 7'h18;
  localparam logic [6:0] IDX_RESULT_HIGH_BYTE = 7'h1A;
  localparam logic [6:0] IDX_RESULT_LOW_BYTE = 7'h1B;
  localparam logic [6:0] IDX_RESULT_RESERVED = 7'h1C;
  localparam logic [6:0] IDX_CHANNEL_STATUS = 7'h1E;
  localparam logic [6:0] IDX_IRQ_STATUS = 7'h60;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h61;

  // ****************************************
  // address decode fields
  // ****************************************
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 8;
  localparam int ADDR_TOP_LSB = 9;

  // ****************************************
  // field values and positions
  // ****************************************
  localparam logic [7:0] FULL_RESET_KEY = 8'hC3;
  localparam int SERIAL_RESET_BIT = 0;
  localparam int RESTART_TRIGGER_BIT = 0;
  localparam int CLEAR_CAL_BIT = 6;
  localparam int EXT_DETECT_BYPASS_BIT = 5;
  localparam int CLOCK_SELECT_BIT = 4;
  localparam int EXC_CODE_MSB = 3;
  localparam logic [6:0] AUX_RESET = 7'h00;
  localparam logic [7:0] RESULT_NOT_AVAILABLE = 8'hFF;
  localparam logic [7:0] RESULT_AVAILABLE = 8'h00;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_UNDEFINED = 2'h2,
    PWR_STANDBY = 2'h3
  } apr_power_t;

  // ****************************************
  // interrupt bits
  // ****************************************
  localparam int IRQ_BITS = 2;
  localparam int IRQ_RESULT_READY = 0;
  localparam int IRQ_STALE_READ = 1;

  // ****************************************
  // ahb-lite encodings
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } apr_bus_t;

endpackage

`default_nettype wire

// [design/apr_ctrl_regs.sv]
/*
  power, keyed reset and converter control/status register bank, ahb-lite slave.
  assumes the converter core sits on the same clock, presents a result with a
  one-cycle strobe, and obeys the restart and calibration-clear pulses.
*/
// Design decision made here: the AHB-Lite register port.
`default_nettype none

module apr_ctrl_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] resultData,
  input wire logic resultValid,
  input wire logic extClockPresent,
  output logic restartPulse,
  output logic softResetPulse,
  output logic calClearPulse,
  output logic serialResetEnable,
  output logic [1:0] powerMode,
  output logic extClockSelected,
  output logic [3:0] excitationCode,
  output logic irq
);

  // ****************************************
  // bus slave
  // ****************************************
  apr_pkg::apr_bus_t busState;
  logic [6:0] regIdx;
  logic regMapped;
  logic regWrite;
  logic accessTaken;
  logic wrEn;
  logic rdEn;
  logic [7:0] wrByte;

  // one wait state so read data leaves a flip-flop
  assign accessTaken = hsel && hready && (htrans == apr_pkg::HTRANS_NONSEQ);
  assign wrEn = (busState == apr_pkg::BUS_DATA) && regWrite && regMapped;
  assign rdEn = (busState == apr_pkg::BUS_DATA) && !regWrite && regMapped;
  assign wrByte = hwdata[7:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busState <= apr_pkg::BUS_IDLE;
      regIdx <= 7'h00;
      regMapped <= 1'b0;
      regWrite <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      case (busState)
        apr_pkg::BUS_IDLE: begin
          if (accessTaken) begin
            busState <= apr_pkg::BUS_DATA;
            regIdx <= haddr[apr_pkg::ADDR_IDX_MSB:apr_pkg::ADDR_IDX_LSB];
            regMapped <= (haddr[31:apr_pkg::ADDR_TOP_LSB] == '0);
            regWrite <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        apr_pkg::BUS_DATA: begin
          busState <= apr_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          busState <= apr_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // only whole-word transfers are expected; hsize is not checked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hresp <= apr_pkg::HRESP_OKAY;
    end else begin
      hresp <= apr_pkg::HRESP_OKAY;
    end
  end

  function automatic logic writeTo(input logic [6:0] idx);
    writeTo = wrEn && (regIdx == idx);
  endfunction

  function automatic logic readOf(input logic [6:0] idx);
    readOf = rdEn && (regIdx == idx);
  endfunction

  // ****************************************
  // keyed reset
  // ****************************************
  logic keyedReset;

  // any other value is simply dropped
  // a process, not an assign: it must wake on the state the helpers read
  always_comb begin
    keyedReset = writeTo(apr_pkg::IDX_RESET_CONTROL) &&
                 (wrByte == apr_pkg::FULL_RESET_KEY);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      softResetPulse <= 1'b0;
    end else begin
      softResetPulse <= keyedReset;
    end
  end

  // ****************************************
  // serial reset enable, write once
  // ****************************************
  logic serialResetLocked;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialResetEnable <= 1'b0;
      serialResetLocked <= 1'b0;
    end else if (keyedReset) begin
      serialResetEnable <= 1'b0;
      serialResetLocked <= 1'b0;
    end else if (writeTo(apr_pkg::IDX_SERIAL_RESET_ENABLE) && !serialResetLocked) begin
      serialResetEnable <= wrByte[apr_pkg::SERIAL_RESET_BIT];
      serialResetLocked <= 1'b1;
    end
  end

  // ****************************************
  // power mode
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerMode <= apr_pkg::PWR_ACTIVE;
    end else if (keyedReset) begin
      powerMode <= apr_pkg::PWR_ACTIVE;
    end else if (writeTo(apr_pkg::IDX_POWER_MODE_CONTROL) &&
                 (wrByte[1:0] != apr_pkg::PWR_UNDEFINED)) begin
      powerMode <= wrByte[1:0];
    end
  end

  // ****************************************
  // auxiliary control
  // ****************************************
  logic [6:0] auxControl;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auxControl <= apr_pkg::AUX_RESET;
    end else if (keyedReset) begin
      auxControl <= apr_pkg::AUX_RESET;
    end else if (writeTo(apr_pkg::IDX_CONVERTER_AUX_CONTROL)) begin
      auxControl <= wrByte[6:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      excitationCode <= 4'h0;
    end else begin
      excitationCode <= auxControl[apr_pkg::EXC_CODE_MSB:0];
    end
  end

  // the setting in force at the key write decides, not the cleared one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      calClearPulse <= 1'b0;
    end else begin
      calClearPulse <= keyedReset && auxControl[apr_pkg::CLEAR_CAL_BIT];
    end
  end

  // ****************************************
  // clock detection and selection
  // ****************************************
  logic extSync1;
  logic extSync2;
  logic extSync3;
  logic extDetected;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extSync3 <= 1'b0;
    end else begin
      extSync1 <= extClockPresent;
      extSync2 <= extSync1;
      extSync3 <= extSync2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extDetected <= 1'b0;
    end else if (extSync2 == extSync3) begin
      extDetected <= extSync3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extClockSelected <= 1'b0;
    end else if (auxControl[apr_pkg::EXT_DETECT_BYPASS_BIT]) begin
      extClockSelected <= auxControl[apr_pkg::CLOCK_SELECT_BIT];
    end else begin
      extClockSelected <= extDetected;
    end
  end

  // ****************************************
  // restart
  // ****************************************
  logic restartReq;

  always_comb begin
    restartReq = keyedReset ||
                 (writeTo(apr_pkg::IDX_CONVERSION_RESTART) &&
                  wrByte[apr_pkg::RESTART_TRIGGER_BIT]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restartPulse <= 1'b0;
    end else begin
      restartPulse <= restartReq;
    end
  end

  // ****************************************
  // conversion result and freshness
  // ****************************************
  logic [15:0] resultHold;
  logic resultFresh;
  logic staleRead;
  logic resultByteRead;

  always_comb begin
    resultByteRead = readOf(apr_pkg::IDX_RESULT_HIGH_BYTE) ||
                     readOf(apr_pkg::IDX_RESULT_LOW_BYTE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultHold <= 16'h0000;
    end else if (resultValid) begin
      resultHold <= resultData;
    end
  end

  // a new result wins over the clear by a read or a restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultFresh <= 1'b0;
    end else if (resultValid) begin
      resultFresh <= 1'b1;
    end else if (restartReq || readOf(apr_pkg::IDX_RESULT_LOW_BYTE)) begin
      resultFresh <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      staleRead <= 1'b0;
    end else if (keyedReset) begin
      staleRead <= 1'b0;
    end else if (resultByteRead) begin
      staleRead <= !resultFresh;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic [apr_pkg::IRQ_BITS-1:0] irqStatus;
  logic [apr_pkg::IRQ_BITS-1:0] irqMask;
  logic [apr_pkg::IRQ_BITS-1:0] irqEvent;
  logic [apr_pkg::IRQ_BITS-1:0] irqClear;

  always_comb begin
    irqEvent = '0;
    irqEvent[apr_pkg::IRQ_RESULT_READY] = resultValid;
    irqEvent[apr_pkg::IRQ_STALE_READ] = resultByteRead && !resultFresh;
    irqClear = '0;
    if (writeTo(apr_pkg::IDX_IRQ_STATUS)) begin
      irqClear = wrByte[apr_pkg::IRQ_BITS-1:0];
    end
  end

  // set beats write-one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= '0;
    end else if (keyedReset) begin
      irqStatus <= irqEvent;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvent;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqMask <= '0;
    end else if (keyedReset) begin
      irqMask <= '0;
    end else if (writeTo(apr_pkg::IDX_IRQ_MASK)) begin
      irqMask <= wrByte[apr_pkg::IRQ_BITS-1:0];
    end
  end

  // one cycle behind the status bits, traded for a registered output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    case (regIdx)
      apr_pkg::IDX_SERIAL_RESET_ENABLE: readByte = {7'h00, serialResetEnable};
      apr_pkg::IDX_POWER_MODE_CONTROL: readByte = {6'h00, powerMode};
      apr_pkg::IDX_CONVERTER_AUX_CONTROL: readByte = {1'b0, auxControl};
      apr_pkg::IDX_RESULT_AVAILABLE_FLAG: begin
        readByte = resultFresh ? apr_pkg::RESULT_AVAILABLE
                               : apr_pkg::RESULT_NOT_AVAILABLE;
      end
      apr_pkg::IDX_RESULT_HIGH_BYTE: readByte = resultHold[15:8];
      apr_pkg::IDX_RESULT_LOW_BYTE: readByte = resultHold[7:0];
      apr_pkg::IDX_RESULT_RESERVED: readByte = 8'h00;
      apr_pkg::IDX_CHANNEL_STATUS: readByte = {7'h00, staleRead};
      apr_pkg::IDX_IRQ_STATUS: readByte = {6'h00, irqStatus};
      apr_pkg::IDX_IRQ_MASK: readByte = {6'h00, irqMask};
      default: readByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdEn) begin
      hrdata <= {24'h00_0000, readByte};
    end else if (busState == apr_pkg::BUS_DATA) begin
      hrdata <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [test/apr_ctrl_regs_asserts.sv]
/*
  concurrent checks on the control register bank ports.
  assumes single word transfers, one wait state, writes acting at data phase.
*/
`default_nettype none

module apr_ctrl_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic restartPulse,
  input wire logic softResetPulse,
  input wire logic serialResetEnable,
  input wire logic [1:0] powerMode,
  input wire logic [3:0] excitationCode,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // transfer tracking
  // ****************************************
  logic pend;
  logic pendWr;
  logic [6:0] pendIdx;
  logic lockSeen;
  wire logic dp = pend && pendWr && !hreadyout;
  wire logic [7:0] wd = hwdata[7:0];
  wire logic keyWr = dp && pendIdx == apr_pkg::IDX_RESET_CONTROL;
  wire logic sreWr = dp && pendIdx == apr_pkg::IDX_SERIAL_RESET_ENABLE;
  wire logic pwrWr = dp && pendIdx == apr_pkg::IDX_POWER_MODE_CONTROL;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'h0;
      pendWr <= 1'h0;
      pendIdx <= 7'h00;
    end else begin
      pend <= hsel && hready && htrans == apr_pkg::HTRANS_NONSEQ;
      pendWr <= hwrite && haddr[31:9] == 23'h000000;
      pendIdx <= haddr[8:2];
    end
  end

  // lock follows the first write, only the key clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockSeen <= 1'h0;
    end else if (keyWr && wd == apr_pkg::FULL_RESET_KEY) begin
      lockSeen <= 1'h0;
    end else if (sreWr) begin
      lockSeen <= 1'h1;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_KEY_RESET: assert property (keyWr && wd == apr_pkg::FULL_RESET_KEY |=>
    softResetPulse && restartPulse && powerMode == 2'h0 && !serialResetEnable)
    else $error("key write without full reset");
  AST_KEY_OTHER: assert property (keyWr && wd != apr_pkg::FULL_RESET_KEY |=>
    !softResetPulse) else $error("non-key value caused reset");
  AST_POWER_SET: assert property (pwrWr && wd[1:0] != 2'h2 |=>
    powerMode == $past(hwdata[1:0])) else $error("power mode not taken");
  AST_POWER_KEEP: assert property (pwrWr && wd[1:0] == 2'h2 |=>
    $stable(powerMode)) else $error("undefined power code changed state");
  AST_RESTART: assert property (dp && pendIdx == apr_pkg::IDX_CONVERSION_RESTART
    && wd[0] |=> restartPulse ##1 !restartPulse) else $error("restart pulse wrong");
  AST_SRE_FIRST: assert property (sreWr && !lockSeen |=>
    serialResetEnable == $past(hwdata[0])) else $error("serial reset enable not set");
  AST_SRE_LOCK: assert property (sreWr && lockSeen |=>
    $stable(serialResetEnable)) else $error("locked enable changed");
  AST_EXC_CODE: assert property (dp && pendIdx == apr_pkg::IDX_CONVERTER_AUX_CONTROL
    |=> ##1 excitationCode == $past(hwdata[3:0], 2)) else $error("excitation code wrong");

  COV_KEY: cover property (keyWr && wd == apr_pkg::FULL_RESET_KEY);
  COV_PWR_UNDEF: cover property (pwrWr && wd[1:0] == 2'h2);
  COV_IRQ: cover property ($rose(irq));
endmodule

bind apr_ctrl_regs apr_ctrl_regs_chk chk_u (
  .clk(clk),
  .rst(rst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .restartPulse(restartPulse),
  .softResetPulse(softResetPulse),
  .serialResetEnable(serialResetEnable),
  .powerMode(powerMode),
  .excitationCode(excitationCode),
  .irq(irq)
);

`default_nettype wire

// [test/apr_host_model.sv]
/*
  host model: single word ahb-lite transfers into the register bank.
  assumes hready is the slave's hreadyout; sets timedOut on a hung transfer.
*/
`default_nettype none

module apr_host_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic timedOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // bus tasks
  // ****************************************
  localparam int READ_GAP = 18000;

  initial begin
    hsel = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    timedOut = 1'h0;
  end

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    @(posedge clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= apr_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hwdata <= ~hwdata; // released data does not keep its last value
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 100);
    r = hrdata;
    if (n >= 100) timedOut <= 1'h1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'h1, {24'h000000, d}, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(a, 1'h0, 32'h00000000, r);
  endtask

  // repeat reads of one result kept 72 us apart
  task automatic space_reads;
    repeat (READ_GAP) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// [test/test_afe_power_reset_adc_ctrl_regs.sv]
/*
  register-level bench for the power, reset and converter control bank.
  assumes the host model for bus cycles and the bound checker beside the dut.
*/
`default_nettype none

module test_afe_power_reset_adc_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // harness
  // ****************************************
  logic clk, rst, hsel, hwrite, hreadyout, hresp, timedOut, irq;
  logic resultValid, extClockPresent, restartPulse, softResetPulse, calClearPulse;
  logic serialResetEnable, extClockSelected;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans, powerMode;
  logic [2:0] hsize;
  logic [3:0] excitationCode;
  logic [15:0] resultData;
  logic [7:0] nRestart, nSoft, nCal;
  int mismatches, n_tests;

  apr_host_model host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .timedOut(timedOut));
  apr_ctrl_regs dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .resultData(resultData),
    .resultValid(resultValid), .extClockPresent(extClockPresent),
    .restartPulse(restartPulse), .softResetPulse(softResetPulse),
    .calClearPulse(calClearPulse), .serialResetEnable(serialResetEnable),
    .powerMode(powerMode), .extClockSelected(extClockSelected),
    .excitationCode(excitationCode), .irq(irq));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // pulses counted, not caught, so sampling order cannot hide one
  always @(posedge clk) begin
    if (restartPulse === 1'h1) nRestart <= nRestart + 8'h01;
    if (softResetPulse === 1'h1) nSoft <= nSoft + 8'h01;
    if (calClearPulse === 1'h1) nCal <= nCal + 8'h01;
  end

  always @(posedge timedOut) begin
    mismatches++;
    complete_run();
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task rc(input logic [31:0] a, input logic [31:0] exp);
    host_u.rd(a, rv);
    chk(rv, exp);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task result(input logic [15:0] v);
    @(posedge clk);
    resultData <= v;
    resultValid <= 1'h1;
    @(posedge clk);
    resultValid <= 1'h0;
  endtask

  task complete_run;
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    rst = 1'h1;
    resultData = 16'h0000;
    resultValid = 1'h0;
    extClockPresent = 1'h0;
    {nRestart, nSoft, nCal} = 24'h000000;
    settle(4);
    rst <= 1'h0;
    rc(32'h20, 32'h0);
    rc(32'h60, 32'hFF);
    chk({31'h0, hresp}, 32'h0);
    host_u.wr(32'h20, 8'hFD);
    rc(32'h20, 32'h1);
    host_u.wr(32'h20, 8'h03);
    rc(32'h20, 32'h3);
    host_u.wr(32'h20, 8'h02);
    rc(32'h20, 32'h3);
    chk({30'h0, powerMode}, 32'h3);
    host_u.wr(32'h20, 8'h00);
    rc(32'h20, 32'h0);
    host_u.wr(32'h08, 8'h01);
    chk({31'h0, serialResetEnable}, 32'h1);
    host_u.wr(32'h08, 8'h00);
    rc(32'h08, 32'h1);
    for (int k = 0; k < 9; k++) begin
      host_u.wr(32'h48, 8'(k));
      settle(2);
      chk({28'h0, excitationCode}, 32'(k));
    end
    host_u.wr(32'h48, 8'h30);
    settle(2);
    chk({31'h0, extClockSelected}, 32'h1);
    host_u.wr(32'h48, 8'h10);
    settle(8);
    chk({31'h0, extClockSelected}, 32'h0);
    extClockPresent <= 1'h1;
    settle(8);
    chk({31'h0, extClockSelected}, 32'h1);
    host_u.wr(32'h2C, 8'h01);
    host_u.wr(32'h2C, 8'hFE);
    settle(2);
    chk({8'h00, nRestart, nSoft, nCal}, 32'h00010000);
    host_u.wr(32'h48, 8'h40);
    host_u.wr(32'h00, 8'h55);
    host_u.wr(32'h00, 8'hC3);
    settle(2);
    chk({8'h00, nRestart, nSoft, nCal}, 32'h00020101);
    rc(32'h48, 32'h0);
    rc(32'h08, 32'h0);
    host_u.wr(32'h08, 8'h01);
    rc(32'h08, 32'h1);
    host_u.wr(32'h00, 8'hC3);
    settle(2);
    chk({8'h00, nRestart, nSoft, nCal}, 32'h00030201);
    result(16'h8001);
    rc(32'h60, 32'h00);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    host_u.wr(32'h184, 8'h01);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    rc(32'h68, 32'h80);
    rc(32'h78, 32'h0);
    rc(32'h6C, 32'h01);
    rc(32'h60, 32'hFF);
    host_u.space_reads();
    rc(32'h6C, 32'h01);
    rc(32'h78, 32'h1);
    rc(32'h70, 32'h0);
    rc(32'h180, 32'h3);
    host_u.wr(32'h180, 8'h03);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    rc(32'h180, 32'h0);
    result(16'h7FFE);
    host_u.wr(32'h2C, 8'h01);
    rc(32'h60, 32'hFF);
    host_u.wr(32'h220, 8'h01);
    rc(32'h20, 32'h0);
    rc(32'h220, 32'h0);
    complete_run();
  end
endmodule

`default_nettype wire
